// [core/lsc_pkg.sv]
// Overview of operation
// - Shift register advances on shift clock rise
// - Last stage bit drives serial output
// - Normal mode latch transparent while strobe high
// - Enable low drives sinks, high blanks
// - Undriven strobe reads low, enable high
// - Three phases: normal, switching, special
// - One-clock enable low pulse starts switching
// - Special strobe pulse loads configuration latch
// - Configuration code sets global current gain
// - Special enable low samples channel errors
// - Error status loaded and shifted out
// - One error flag per channel, all causes
// - Return to normal clears error flags
// - Enable low drives outputs in every mode
package lsc_pkg;

   // Channel count and shift register width
   localparam int unsigned CHANNELS   = 8;
   // Depth of the error snapshot buffer
   localparam int unsigned DIAG_DEPTH = 16;

   // Values after reset
   localparam logic [7:0] SHIFT_RESET  = 8'h00;
   localparam logic [7:0] LATCH_RESET  = 8'h00;
   localparam logic [7:0] GAIN_RESET   = 8'hff;
   localparam logic [7:0] ERROR_RESET  = 8'h00;
   localparam logic [1:0] OE_HIST_INIT = 2'h3;

   // Bit positions in the enable history
   localparam int unsigned HIST_OLD = 1;
   localparam int unsigned HIST_NEW = 0;

   // Operating phases
   typedef enum logic [1:0] {
      PH_NORMAL  = 2'b00,
      PH_SWITCH  = 2'b01,
      PH_SPECIAL = 2'b10
   } lsc_phase_type;

endpackage

// [core/lsc_fifo.sv]
`timescale 1ns/1ps
module lsc_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 16
) (
   input  wire logic             i_clock,     // System clock
   input  wire logic             i_rst,       // Asynchronous reset, active high
   input  wire logic             i_in_valid,  // Write request
   output logic                  o_in_ready,  // Space available
   input  wire logic [WIDTH-1:0] i_in_data,   // Write word
   output logic                  o_out_valid, // Word available
   input  wire logic             i_out_ready, // Read request
   output logic [WIDTH-1:0]      o_out_data   // Head word
);

   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0]      wr_ptr_q;
   logic [AW:0]      rd_ptr_q;
   logic             push;
   logic             pop;

   // Full when pointers differ only in the wrap bit
   assign o_in_ready  = !((wr_ptr_q[AW] != rd_ptr_q[AW]) &&
                          (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]));
   assign o_out_valid = (wr_ptr_q != rd_ptr_q);
   assign o_out_data  = mem_q[rd_ptr_q[AW-1:0]];
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;

   // Storage array
   always_ff @(posedge i_clock) begin
      if (push) begin
         mem_q[wr_ptr_q[AW-1:0]] <= i_in_data;
      end
   end

   // Pointer update
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
      end
   end

endmodule

// [core/lsc_top.sv]
`timescale 1ns/1ps
module lsc_top #(
   parameter bit SHORT_LED_SUPPORT = 1'b1 // Variant detects short to LED supply
) (
   input  wire logic       i_clock,             // System clock, 100 MHz
   input  wire logic       i_rst,               // Asynchronous reset, active high
   input  wire logic       i_shift_clock,       // Serial shift clock level
   input  wire logic       i_serial_in,         // Serial data in
   input  wire logic       i_latch_strobe,      // Latch strobe level
   input  wire logic       i_latch_strobe_drv,  // Strobe pin is driven
   input  wire logic       i_output_enable_n,   // Output enable, active low
   input  wire logic       i_output_enable_drv, // Enable pin is driven
   input  wire logic [7:0] i_fault_open,        // Open load per channel
   input  wire logic [7:0] i_fault_short_gnd,   // Short to ground per channel
   input  wire logic [7:0] i_fault_short_led,   // Short to LED supply per channel
   input  wire logic       i_fault_overtemp,    // Overtemperature, all channels
   input  wire logic       i_diag_ready,        // Snapshot consumer ready
   output logic            o_serial_out,        // Serial data out
   output logic [7:0]      o_sink_channels,     // Channel sink enables
   output logic [7:0]      o_current_gain,      // Global current gain code
   output logic            o_special_mode,      // Special phase active
   output logic [7:0]      o_diag_word,         // Error snapshot word
   output logic            o_diag_valid         // Error snapshot valid
);

   logic [7:0]             shift_q;
   logic [7:0]             latch_q;
   logic [7:0]             gain_q;
   logic [7:0]             error_q;
   logic [7:0]             sink_q;
   logic                   sclk_q;
   logic                   le_q;
   logic                   oe_n_q;
   logic [1:0]             oe_hist_q;
   logic                   sel_special_q;
   logic                   snap_pend_q;
   logic [7:0]             snap_q;
   logic [7:0]             diag_word_q;
   logic                   diag_valid_q;
   lsc_pkg::lsc_phase_type phase_q;
   logic                   le;
   logic                   oe_n;
   logic                   shift_edge;
   logic                   le_rise;
   logic                   oe_rise;
   logic                   switch_pulse;
   logic                   err_load;
   logic [7:0]             fault_vec;
   logic                   fifo_in_ready;
   logic                   fifo_out_valid;
   logic [7:0]             fifo_out_data;
   logic                   drain;

   // Pin levels with pull defaults for undriven inputs
   assign le   = i_latch_strobe_drv ? i_latch_strobe : 1'b0;
   assign oe_n = i_output_enable_drv ? i_output_enable_n : 1'b1;

   // Edge detection on sampled pins
   assign shift_edge = i_shift_clock && !sclk_q;
   assign le_rise    = le && !le_q;
   assign oe_rise    = oe_n && !oe_n_q;

   // A low level seen at exactly one shift edge, high before and after
   assign switch_pulse = shift_edge && oe_hist_q[lsc_pkg::HIST_OLD] &&
                         !oe_hist_q[lsc_pkg::HIST_NEW] && oe_n;

   // Error status captured into the shift register as enable rises
   assign err_load = (phase_q == lsc_pkg::PH_SPECIAL) && oe_rise;

   // Every cause sets the same per-channel flag
   assign fault_vec = i_fault_open | i_fault_short_gnd |
                      (i_fault_short_led & {8{SHORT_LED_SUPPORT}}) |
                      {8{i_fault_overtemp}};

   assign drain = !diag_valid_q || i_diag_ready;

   // Registered copies of pin levels
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         sclk_q <= 1'b0;
         le_q   <= 1'b0;
         oe_n_q <= 1'b1;
      end else begin
         sclk_q <= i_shift_clock;
         le_q   <= le;
         oe_n_q <= oe_n;
      end
   end

   // Enable level history at shift edges
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         oe_hist_q <= lsc_pkg::OE_HIST_INIT;
      end else if (shift_edge) begin
         oe_hist_q <= {oe_hist_q[lsc_pkg::HIST_NEW], oe_n};
      end
   end

   // Phase machine
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         phase_q       <= lsc_pkg::PH_NORMAL;
         sel_special_q <= 1'b0;
      end else begin
         unique case (phase_q)
            lsc_pkg::PH_NORMAL, lsc_pkg::PH_SPECIAL: begin
               if (switch_pulse) begin
                  phase_q       <= lsc_pkg::PH_SWITCH;
                  sel_special_q <= le;
               end
            end
            lsc_pkg::PH_SWITCH: begin
               phase_q <= sel_special_q ? lsc_pkg::PH_SPECIAL
                                        : lsc_pkg::PH_NORMAL;
            end
            default: begin
               phase_q <= lsc_pkg::PH_NORMAL;
            end
         endcase
      end
   end

   // Serial shift register, error load has priority over a shift
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         shift_q <= lsc_pkg::SHIFT_RESET;
      end else if (err_load) begin
         shift_q <= error_q;
      end else if (shift_edge) begin
         shift_q <= {shift_q[6:0], i_serial_in};
      end
   end

   // Output data latch, transparent while strobe high in normal phase
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         latch_q <= lsc_pkg::LATCH_RESET;
      end else if ((phase_q == lsc_pkg::PH_NORMAL) && le) begin
         latch_q <= shift_q;
      end
   end

   // Configuration latch, loaded on strobe rise in special phase
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         gain_q <= lsc_pkg::GAIN_RESET;
      end else if ((phase_q == lsc_pkg::PH_SPECIAL) && le_rise) begin
         gain_q <= shift_q;
      end
   end

   // Error flags: sampled while enabled in special, cleared on return
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         error_q <= lsc_pkg::ERROR_RESET;
      end else if ((phase_q == lsc_pkg::PH_SPECIAL) && !oe_n) begin
         error_q <= error_q | fault_vec;
      end else if ((phase_q == lsc_pkg::PH_SWITCH) && !sel_special_q) begin
         error_q <= lsc_pkg::ERROR_RESET;
      end
   end

   // Channel sinks follow the latch while enable is low, in any phase
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         sink_q <= 8'h00;
      end else begin
         sink_q <= oe_n ? 8'h00 : latch_q;
      end
   end

   // Snapshot waits here until the buffer has room
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         snap_pend_q <= 1'b0;
         snap_q      <= lsc_pkg::ERROR_RESET;
      end else if (err_load) begin
         snap_pend_q <= 1'b1;
         snap_q      <= error_q;
      end else if (fifo_in_ready) begin
         snap_pend_q <= 1'b0;
      end
   end

   // Snapshot buffer
   lsc_fifo #(
      .WIDTH (lsc_pkg::CHANNELS),
      .DEPTH (lsc_pkg::DIAG_DEPTH)
   ) u_diag_fifo (
      .i_clock     (i_clock),
      .i_rst       (i_rst),
      .i_in_valid  (snap_pend_q),
      .o_in_ready  (fifo_in_ready),
      .i_in_data   (snap_q),
      .o_out_valid (fifo_out_valid),
      .i_out_ready (drain),
      .o_out_data  (fifo_out_data)
   );

   // Registered snapshot output stage
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         diag_valid_q <= 1'b0;
         diag_word_q  <= lsc_pkg::ERROR_RESET;
      end else if (drain) begin
         diag_valid_q <= fifo_out_valid;
         if (fifo_out_valid) begin
            diag_word_q <= fifo_out_data;
         end
      end
   end

   // Outputs straight from flip-flops, special mode decoded from phase_q
   assign o_serial_out    = shift_q[7];
   assign o_sink_channels = sink_q;
   assign o_current_gain  = gain_q;
   assign o_special_mode  = (phase_q == lsc_pkg::PH_SPECIAL);
   assign o_diag_word     = diag_word_q;
   assign o_diag_valid    = diag_valid_q;

   // Checks
   sequence s_pulse_high;
      switch_pulse && le;
   endsequence

   sequence s_pulse_low;
      switch_pulse && !le;
   endsequence

   sequence s_to_special;
      (phase_q == lsc_pkg::PH_SWITCH) ##1 (phase_q == lsc_pkg::PH_SPECIAL);
   endsequence

   sequence s_to_normal;
      (phase_q == lsc_pkg::PH_SWITCH) ##1 (phase_q == lsc_pkg::PH_NORMAL);
   endsequence

   property p_shift;
      @(posedge i_clock) disable iff (i_rst)
      shift_edge && !err_load |=> shift_q == {$past(shift_q[6:0]), $past(i_serial_in)};
   endproperty
   a_shift: assert property (p_shift) else $error("shift register did not advance");

   property p_serial_out;
      @(posedge i_clock) disable iff (i_rst)
      shift_edge && !err_load |=> o_serial_out == $past(shift_q[6]);
   endproperty
   a_serial_out: assert property (p_serial_out) else $error("serial out wrong bit");

   property p_transparent;
      @(posedge i_clock) disable iff (i_rst)
      (phase_q == lsc_pkg::PH_NORMAL) && le |=> latch_q == $past(shift_q);
   endproperty
   a_transparent: assert property (p_transparent) else $error("latch not transparent");

   property p_hold;
      @(posedge i_clock) disable iff (i_rst)
      !le |=> $stable(latch_q);
   endproperty
   a_hold: assert property (p_hold) else $error("latch changed with strobe low");

   property p_blank;
      @(posedge i_clock) disable iff (i_rst)
      oe_n |=> o_sink_channels == 8'h00;
   endproperty
   a_blank: assert property (p_blank) else $error("sinks on while blanked");

   property p_drive;
      @(posedge i_clock) disable iff (i_rst)
      !oe_n |=> o_sink_channels == $past(latch_q);
   endproperty
   a_drive: assert property (p_drive) else $error("sinks do not follow latch");

   property p_pull;
      @(posedge i_clock) disable iff (i_rst)
      !i_output_enable_drv && !i_latch_strobe_drv |=> o_sink_channels == 8'h00 ##0 $stable(latch_q);
   endproperty
   a_pull: assert property (p_pull) else $error("pull defaults not honoured");

   property p_phase_legal;
      @(posedge i_clock) disable iff (i_rst)
      phase_q != 2'b11;
   endproperty
   a_phase_legal: assert property (p_phase_legal) else $error("illegal phase code");

   property p_enter_special;
      @(posedge i_clock) disable iff (i_rst)
      s_pulse_high |=> s_to_special;
   endproperty
   a_enter_special: assert property (p_enter_special) else $error("special not entered");

   property p_enter_normal;
      @(posedge i_clock) disable iff (i_rst)
      s_pulse_low |=> s_to_normal ##1 (error_q == 8'h00);
   endproperty
   a_enter_normal: assert property (p_enter_normal) else $error("normal return failed");

   property p_config;
      @(posedge i_clock) disable iff (i_rst)
      (phase_q == lsc_pkg::PH_SPECIAL) && le_rise |=>
         o_current_gain == $past(shift_q) && $stable(latch_q);
   endproperty
   a_config: assert property (p_config) else $error("configuration not latched");

   property p_gain_cause;
      @(posedge i_clock) disable iff (i_rst)
      $changed(o_current_gain) |-> $past((phase_q == lsc_pkg::PH_SPECIAL) && le_rise);
   endproperty
   a_gain_cause: assert property (p_gain_cause) else $error("gain changed unprompted");

   property p_sample;
      @(posedge i_clock) disable iff (i_rst)
      (phase_q == lsc_pkg::PH_SPECIAL) && !oe_n |=>
         (error_q & $past(fault_vec)) == $past(fault_vec);
   endproperty
   a_sample: assert property (p_sample) else $error("fault not recorded");

   property p_err_load;
      @(posedge i_clock) disable iff (i_rst)
      err_load |=> shift_q == $past(error_q) ##1 snap_pend_q || $past(fifo_in_ready);
   endproperty
   a_err_load: assert property (p_err_load) else $error("error status not loaded");

   property p_clear;
      @(posedge i_clock) disable iff (i_rst)
      (phase_q == lsc_pkg::PH_SWITCH) && !sel_special_q |=> error_q == 8'h00;
   endproperty
   a_clear: assert property (p_clear) else $error("error flags not cleared");

endmodule

// [sim/lsc_ctrl_model.sv]
`timescale 1ns/1ps
module lsc_ctrl_model (
   input  wire logic i_clock,          // System clock
   output logic      o_shift_clock,    // Serial shift clock
   output logic      o_serial_in,      // Serial data to the driver
   output logic      o_latch_strobe,   // Latch strobe
   output logic      o_output_enable_n // Output enable, active low
);
   // Idle levels: shift clock parked low, outputs blanked
   initial begin
      o_shift_clock     = 1'b0;
      o_serial_in       = 1'b0;
      o_latch_strobe    = 1'b0;
      o_output_enable_n = 1'b1;
   end

   // Let n edges pass, then step just off the edge
   task automatic step(input int n);
      repeat (n) @(posedge i_clock);
      #1;
   endtask

   // One shift clock period, two cycles high and two low
   task automatic rise(input logic d);
      o_serial_in   = d;
      o_shift_clock = 1'b1;
      step(2);
      o_shift_clock = 1'b0;
      o_serial_in   = ~d; // Data no longer held, show the inverse
      step(2);
   endtask

   // Enable low pulse spanning one shift clock, strobe picks the target
   task automatic mode(input logic sel);
      o_output_enable_n = 1'b1;
      rise(1'b1);
      o_output_enable_n = 1'b0;
      rise(1'b1);
      o_output_enable_n = 1'b1;
      o_latch_strobe    = sel;
      rise(1'b1);
      o_latch_strobe    = 1'b0;
      step(2);
   endtask

   // Positive strobe pulse, loads a latch
   task automatic strobe_pulse();
      o_latch_strobe = 1'b1;
      step(2);
      o_latch_strobe = 1'b0;
      step(2);
   endtask

   // Enable low for n cycles, the rise loads the error status
   task automatic oe_pulse(input int n);
      o_output_enable_n = 1'b0;
      step(n);
      o_output_enable_n = 1'b1;
      step(4);
   endtask
endmodule

// [sim/lsc_top_tb.sv]
`timescale 1ns/1ps
module lsc_top_tb;
   logic       clock;
   logic       rst;
   logic       sc;
   logic       sin;
   logic       ls;
   logic       ls_drv;
   logic       oe_n;
   logic       oe_drv;
   logic [7:0] f_open;
   logic [7:0] f_gnd;
   logic [7:0] f_led;
   logic       f_ot;
   logic       diag_ready;
   logic       sout;
   logic [7:0] sinks;
   logic [7:0] gain;
   logic       special;
   logic [7:0] dword;
   logic       dvalid;
   logic [7:0] ref_sh;
   int         fail_count;
   int         tests_run;
   int         cycles;

   lsc_ctrl_model m (.i_clock(clock), .o_shift_clock(sc), .o_serial_in(sin),
      .o_latch_strobe(ls), .o_output_enable_n(oe_n));

   lsc_top dut (.i_clock(clock), .i_rst(rst), .i_shift_clock(sc), .i_serial_in(sin),
      .i_latch_strobe(ls), .i_latch_strobe_drv(ls_drv), .i_output_enable_n(oe_n),
      .i_output_enable_drv(oe_drv), .i_fault_open(f_open), .i_fault_short_gnd(f_gnd),
      .i_fault_short_led(f_led), .i_fault_overtemp(f_ot), .i_diag_ready(diag_ready),
      .o_serial_out(sout), .o_sink_channels(sinks), .o_current_gain(gain),
      .o_special_mode(special), .o_diag_word(dword), .o_diag_valid(dvalid));

   // Clock generation
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // Hang guard
   always @(posedge clock) begin
      cycles++;
      if (cycles == 6000) begin
         fail_count++;
         end_sim();
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Drive all fault inputs together
   task automatic set_faults(input logic [7:0] open_v, input logic [7:0] gnd_v,
                             input logic [7:0] led_v, input logic ot_v);
      f_open = open_v;
      f_gnd  = gnd_v;
      f_led  = led_v;
      f_ot   = ot_v;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   // Shift a byte MSB first, following the serial output bit by bit
   task automatic shift_chk(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         m.rise(b[i]);
         ref_sh = {ref_sh[6:0], b[i]};
         check(sout, ref_sh[7]);
      end
   endtask

   task automatic mode(input logic sel);
      m.mode(sel);
      ref_sh = {ref_sh[4:0], 3'h7};
      check(special, sel);
   endtask

   // Wait for a snapshot and take it
   task automatic take_diag(input logic [7:0] exp);
      for (int k = 0; k < 10 && dvalid !== 1'b1; k++) tick(1);
      check(dvalid, 1'b1);
      check(dword, exp);
      diag_ready = 1'b1;
      tick(1);
      diag_ready = 1'b0;
   endtask

   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Values straight after reset
   task automatic t_reset();
      check(sout, 1'b0);
      check(sinks, 8'h00);
      check(gain, 8'hff);
      check(special, 1'b0);
      check(dvalid, 1'b0);
   endtask

   // Shift, cascade output, transparent and held latch, blanking
   task automatic t_normal();
      shift_chk(8'ha5);
      shift_chk(8'h3c);
      m.o_latch_strobe = 1'b1;
      tick(3);
      m.o_latch_strobe    = 1'b0;
      m.o_output_enable_n = 1'b0;
      tick(3);
      check(sinks, 8'h3c);
      m.o_latch_strobe = 1'b1;
      shift_chk(8'hc3);
      tick(2);
      check(sinks, 8'hc3);
      m.o_latch_strobe = 1'b0;
      shift_chk(8'h11);
      tick(2);
      check(sinks, 8'hc3);
      m.o_output_enable_n = 1'b1;
      tick(3);
      check(sinks, 8'h00);
   endtask

   // Undriven pins fall back to their pull levels
   task automatic t_pulls();
      m.o_output_enable_n = 1'b0;
      oe_drv = 1'b0;
      tick(3);
      check(sinks, 8'h00);
      oe_drv = 1'b1;
      tick(3);
      check(sinks, 8'hc3);
      ls_drv = 1'b0;
      m.o_latch_strobe = 1'b1;
      shift_chk(8'h0f);
      tick(2);
      check(sinks, 8'hc3);
      oe_drv = 1'b0;
      tick(3);
      check(sinks, 8'h00);
      oe_drv = 1'b1;
      m.o_latch_strobe    = 1'b0;
      m.o_output_enable_n = 1'b1;
      ls_drv = 1'b1;
      tick(1);
   endtask

   // A low pulse two shift clocks long leaves the mode alone
   task automatic t_long_pulse();
      m.rise(1'b1);
      m.o_output_enable_n = 1'b0;
      m.rise(1'b1);
      m.rise(1'b1);
      m.o_output_enable_n = 1'b1;
      m.o_latch_strobe = 1'b1;
      m.rise(1'b1);
      m.o_latch_strobe = 1'b0;
      ref_sh = {ref_sh[3:0], 4'hf};
      tick(3);
      check(special, 1'b0);
   endtask

   // Special mode: gain codes, latch kept, error read back
   task automatic t_special();
      logic [7:0] codes [3];
      codes = '{8'h00, 8'h80, 8'h7e};
      shift_chk(8'hff);
      m.strobe_pulse();
      mode(1'b1);
      foreach (codes[i]) begin
         shift_chk(codes[i]);
         m.strobe_pulse();
         check(gain, codes[i]);
      end
      set_faults(8'h01, 8'h10, 8'h80, 1'b0);
      m.o_output_enable_n = 1'b0;
      tick(3);
      check(sinks, 8'hff);
      m.o_output_enable_n = 1'b1;
      tick(4);
      ref_sh = 8'h91;
      check(sout, 1'b1);
      shift_chk(8'h00);
      take_diag(8'h91);
   endtask

   // Overtemperature, then stall the consumer until the buffer is full
   task automatic t_fill();
      int cnt;
      cnt  = 0;
      set_faults(8'h00, 8'h00, 8'h00, 1'b1);
      m.oe_pulse(2);
      check(sout, 1'b1);
      take_diag(8'hff);
      repeat (20) m.oe_pulse(1);
      check(dvalid, 1'b1);
      diag_ready = 1'b1;
      repeat (40) begin
         if (dvalid === 1'b1) begin
            cnt++;
            check(dword, 8'hff);
         end
         tick(1);
      end
      diag_ready = 1'b0;
      // Output stage, sixteen buffered and one pending snapshot survive
      check(8'(cnt), 8'h12);
      check(dvalid, 1'b0);
   endtask

   // Return to normal clears the error flags
   task automatic t_return();
      set_faults(8'h00, 8'h00, 8'h00, 1'b0);
      mode(1'b0);
      // The enable rise that ends the switch pulse loads a last snapshot
      take_diag(8'hff);
      mode(1'b1);
      m.oe_pulse(2);
      ref_sh = 8'h00;
      check(sout, 1'b0);
      take_diag(8'h00);
      mode(1'b0);
   endtask

   // Main sequence
   initial begin
      rst        = 1'b1;
      ls_drv     = 1'b1;
      oe_drv     = 1'b1;
      set_faults(8'h00, 8'h00, 8'h00, 1'b0);
      diag_ready = 1'b0;
      ref_sh     = 8'h00;
      fail_count = 0;
      tests_run  = 0;
      cycles     = 0;
      tick(10);
      rst = 1'b0;
      tick(1);
      t_reset();
      t_normal();
      t_pulls();
      t_long_pulse();
      t_special();
      t_fill();
      t_return();
      end_sim();
   end
endmodule
